/* sac_analog_model.sv */
// Purpose: comparator array stand-in for the converter control
// Assumes: each channel level is given as an ideal 10-bit code
// Notes: comparator answers one cycle after the trial code
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model
	import sac_pkg::*;
(
	input wire logic CLK,
	input wire logic [7:0] ANALOG_SEL,
	input wire logic [9:0] DAC_CODE,
	input wire logic CONV_POWER,
	input wire logic [9:0] VIN [8],
	output logic COMP_OUT
);
	logic [9:0] vin_sel;
	initial COMP_OUT = 1'h0;
	always_comb begin
		vin_sel = 10'h000;
		for (int i = 0; i < 8; i++) begin
			if (ANALOG_SEL[i]) vin_sel = VIN[i];
		end
	end
	// powered down core gives noise, never a held level
	always_ff @(posedge CLK) begin
		COMP_OUT <= CONV_POWER ? (vin_sel >= DAC_CODE) : !COMP_OUT;
	end
endmodule
`default_nettype wire

/* sac_control.sv */
// Purpose: control logic of an eight-channel 10-bit SAR converter
// Assumes: comparator in analog core; AXI4-Lite register access
// Notes: conversion clock is a divided enable on CLK
// Notes on behaviour
// - full scale 3ff, low reference 000
// - status/control write starts a conversion
// - conversion lasts 16 converter clocks
// - continuous mode overwrites result unless interlocked
// - continuous mode restarts until bit cleared
// - done flag set until data read
// - single mode converts once per write
// - four justification modes from clock register
// - left mode, high then low read interlock
// - right mode two high, eight low
// - signed mode inverts result top bit
// - truncation puts eight msbs low, no lock
// - interrupt mode replaces done flag
// - selected pin forced analog, reads zero
// - unselected pins stay ordinary port pins
// - mux routes one of eight channels
// - idle mode keeps converter running
// - halt aborts conversion, no restart on exit
// - all-ones channel select powers converter off
// - divider 1,2,4,8 or 16 when top set
// - data read or control write clears interrupt
`timescale 1ns/100ps
`default_nettype none
module sac_control
	import sac_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [7:0] PORT_PIN_IN,
	input wire logic [7:0] PORT_DATA,
	input wire logic [7:0] PORT_DIR,
	input wire logic COMP_OUT,
	input wire logic BUS_CLK_EN,
	input wire logic IDLE_MODE,
	input wire logic HALT_MODE,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE,
	output logic [7:0] ANALOG_SEL,
	output logic [9:0] DAC_CODE,
	output logic SAMPLE,
	output logic CONV_POWER,
	output logic CONV_IRQ
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_BITS, ST_DONE} sac_st_t;
	sac_st_t st_reg, st_next;
	logic [4:0] ch_reg;
	logic cont_reg, ien_reg, done_reg, irq_reg;
	logic [7:0] clk_reg;
	logic [9:0] sar_reg, res_reg;
	logic [4:0] cyc_reg;
	logic [3:0] bit_reg;
	logic [3:0] div_reg;
	logic lock_reg;
	logic [1:0] lowsel_reg;
	logic [7:0] pin_s1_reg, pin_s2_reg;
	logic cmp_s1_reg, cmp_s2_reg, halt_s1_reg, halt_s2_reg;
	logic [7:0] lo_latch_reg;
	logic [3:0] aw_addr_reg, ar_addr_reg;
	logic [31:0] w_data_reg;
	logic aw_have_reg, w_have_reg;
	// axi write path
	wire wr_go = aw_have_reg && w_have_reg && !S_AXI_BVALID;
	wire wr_lane0 = S_AXI_WSTRB[0];
	wire wr_sc = wr_go && aw_addr_reg == SAC_OFS_STATUS_CONTROL;
	wire wr_ck = wr_go && aw_addr_reg == SAC_OFS_CLOCK;
	wire wr_ok = aw_addr_reg == SAC_OFS_STATUS_CONTROL ||
		aw_addr_reg == SAC_OFS_CLOCK;
	wire rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
	wire rd_hi = rd_go && S_AXI_ARADDR == SAC_OFS_RESULT_HIGH;
	wire rd_lo = rd_go && S_AXI_ARADDR == SAC_OFS_RESULT_LOW;
	sac_just_t mode;
	assign mode = sac_just_t'(clk_reg[SAC_BIT_MODE_LO +: 2]);
	wire power_off = ch_reg == SAC_CH_OFF;
	// the channel being written decides, not the one it replaces
	wire wr_off = wr_lane0 ? w_data_reg[4:0] == SAC_CH_OFF : power_off;
	wire halted = halt_s2_reg;
	wire [7:0] sel_onehot = (ch_reg[4:3] == 2'h0) ?
		(8'h01 << ch_reg[2:0]) : 8'h00;
	// divider: 1,2,4,8 or 16 input clocks per converter tick
	wire [2:0] div_sel = clk_reg[SAC_BIT_DIV_LO +: 3];
	wire [3:0] div_max = div_sel[2] ? 4'hf :
		(4'h1 << div_sel[1:0]) - 4'h1;
	wire src_en = clk_reg[SAC_BIT_ICLK] ? 1'b1 : BUS_CLK_EN;
	wire tick = src_en && div_reg == div_max;
	wire conv_end = st_reg == ST_DONE && tick;
	// interlock applies only to the paired byte modes
	wire locked = lock_reg && mode != SAC_TRUNC;
	wire store = conv_end && !locked;
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: st_next = ST_IDLE;
			ST_SAMPLE: if (tick && cyc_reg == 5'h04) st_next = ST_BITS;
			ST_BITS: if (tick && bit_reg == 4'h0) st_next = ST_DONE;
			ST_DONE: if (tick) st_next = cont_reg ? ST_SAMPLE : ST_IDLE;
			default: st_next = ST_IDLE;
		endcase
		if (power_off || halted) st_next = ST_IDLE;
		if (wr_sc)
			st_next = (wr_off || halted) ? ST_IDLE : ST_SAMPLE;
	end
	always_ff @(posedge CLK) begin
		pin_s1_reg <= PORT_PIN_IN;
		pin_s2_reg <= pin_s1_reg;
		cmp_s1_reg <= COMP_OUT;
		cmp_s2_reg <= cmp_s1_reg;
		halt_s1_reg <= HALT_MODE;
		halt_s2_reg <= halt_s1_reg;
	end
	// sequencer: 5 sample ticks + 10 bit ticks + 1 done tick = 16 clocks;
	// the divider is held at zero while idle, so the first tick comes a full tick after the start
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_reg <= ST_IDLE;
			div_reg <= 4'h0;
			cyc_reg <= 5'h0;
			bit_reg <= 4'h0;
			sar_reg <= 10'h000;
		end else begin
			st_reg <= st_next;
			div_reg <= (tick || st_reg == ST_IDLE) ? 4'h0 :
				(src_en ? div_reg + 4'h1 : div_reg);
			if (wr_sc || (st_reg == ST_DONE && tick)) begin
				cyc_reg <= 5'h0;
				bit_reg <= 4'h9;
				sar_reg <= 10'h200;
			end else if (tick && st_reg == ST_SAMPLE) begin
				cyc_reg <= cyc_reg + 5'h1;
			end else if (tick && st_reg == ST_BITS) begin
				// keep the trial bit when input is at or above it
				sar_reg[bit_reg] <= cmp_s2_reg;
				if (bit_reg != 4'h0)
					sar_reg[bit_reg - 4'h1] <= 1'b1;
				bit_reg <= bit_reg - 4'h1;
			end
		end
	end
	// registers, flags and result
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ch_reg <= SAC_CH_RESET;
			cont_reg <= 1'b0;
			ien_reg <= 1'b0;
			clk_reg <= SAC_CLOCK_RESET;
			done_reg <= 1'b0;
			irq_reg <= 1'b0;
			res_reg <= 10'h000;
			lock_reg <= 1'b0;
			lo_latch_reg <= 8'h00;
		end else begin
			if (wr_sc && wr_lane0) begin
				ch_reg <= w_data_reg[4:0];
				cont_reg <= w_data_reg[SAC_BIT_CONT];
				ien_reg <= w_data_reg[SAC_BIT_IEN];
			end
			if (wr_ck && S_AXI_WSTRB[0])
				clk_reg <= w_data_reg[7:0];
			if (store)
				res_reg <= sar_reg;
			// set wins over the clearing read
			if (store && !ien_reg)
				done_reg <= 1'b1;
			else if (rd_hi || rd_lo || ien_reg)
				done_reg <= 1'b0;
			if (store && ien_reg)
				irq_reg <= 1'b1;
			else if (rd_hi || rd_lo || wr_sc)
				irq_reg <= 1'b0;
			if (rd_hi && mode != SAC_TRUNC) begin
				lock_reg <= 1'b1;
				lo_latch_reg <= lowsel_reg == 2'h0 ?
					{res_reg[1:0], 6'h00} : res_reg[7:0];
			end else if (rd_lo) begin
				lock_reg <= 1'b0;
			end
		end
	end
	// formatting of the held result
	logic [7:0] hi_view, lo_view;
	always_comb begin
		case (mode)
			SAC_LEFT: begin
				hi_view = res_reg[9:2];
				lo_view = {res_reg[1:0], 6'h00};
			end
			SAC_RIGHT: begin
				hi_view = {6'h00, res_reg[9:8]};
				lo_view = res_reg[7:0];
			end
			SAC_SIGNED: begin
				hi_view = {~res_reg[9], res_reg[8:2]};
				lo_view = {res_reg[1:0], 6'h00};
			end
			default: begin
				hi_view = 8'h00;
				lo_view = res_reg[9:2];
			end
		endcase
	end
	wire [7:0] lo_out = locked ? lo_latch_reg : lo_view;
	wire [7:0] sc_view = {done_reg, ien_reg, cont_reg, ch_reg};
	wire [7:0] port_view = pin_s2_reg & ~sel_onehot;
	logic [7:0] rd_mux;
	always_comb begin
		case (S_AXI_ARADDR)
			SAC_OFS_STATUS_CONTROL: rd_mux = sc_view;
			SAC_OFS_RESULT_HIGH: rd_mux = hi_view;
			SAC_OFS_RESULT_LOW: rd_mux = lo_out;
			SAC_OFS_CLOCK: rd_mux = clk_reg;
			default: rd_mux = port_view;
		endcase
	end
	// axi channels
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= SAC_RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= SAC_RESP_OKAY;
			lowsel_reg <= 2'h0;
		end else begin
			S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY;
			S_AXI_WREADY <= !w_have_reg && !S_AXI_WREADY;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_reg <= 1'b1;
				w_data_reg <= {1'b0, S_AXI_WDATA[30:0]};
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? SAC_RESP_OKAY : SAC_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY &&
				S_AXI_ARVALID;
			if (rd_go) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {24'h0, rd_mux};
				S_AXI_RRESP <= S_AXI_ARADDR[3:2] != 2'h0 ||
					S_AXI_ARADDR == SAC_OFS_STATUS_CONTROL ?
					SAC_RESP_OKAY : SAC_RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
			lowsel_reg <= (mode == SAC_RIGHT) ? 2'h1 : 2'h0;
		end
	end
	// pins and analog core drive
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PIN_OUT <= 8'h00;
			PIN_OE <= 8'h00;
			ANALOG_SEL <= 8'h00;
			DAC_CODE <= 10'h000;
			SAMPLE <= 1'b0;
			CONV_POWER <= 1'b0;
			CONV_IRQ <= 1'b0;
		end else begin
			PIN_OUT <= PORT_DATA & ~sel_onehot;
			PIN_OE <= PORT_DIR & ~sel_onehot;
			ANALOG_SEL <= power_off ? 8'h00 : sel_onehot;
			DAC_CODE <= sar_reg;
			SAMPLE <= st_reg == ST_SAMPLE;
			CONV_POWER <= !power_off && !halted;
			CONV_IRQ <= irq_reg;
		end
	end
	// checks
	// converter ticks seen since the start, for the conversion length
	logic [4:0] chk_ticks_reg;
	always_ff @(posedge CLK) begin
		if (!RST_N || wr_sc || conv_end || st_reg == ST_IDLE) begin
			chk_ticks_reg <= 5'h00;
		end else if (tick && chk_ticks_reg != 5'h1f) begin
			chk_ticks_reg <= chk_ticks_reg + 5'h01;
		end
	end
	chk_conv_ticks: assert property (@(posedge CLK) disable iff (!RST_N)
		conv_end |-> chk_ticks_reg == SAC_CONV_CYCLES - 5'h01)
		else $error("conversion length not sixteen ticks");
	chk_write_starts: assert property (@(posedge CLK) disable iff (!RST_N)
		wr_sc && !wr_off && !halted |=> st_reg == ST_SAMPLE)
		else $error("control write did not start a conversion");
	chk_off_idle: assert property (@(posedge CLK) disable iff (!RST_N)
		power_off && !wr_sc |=> st_reg == ST_IDLE)
		else $error("sequencer ran with converter powered off");
	chk_off_nosel: assert property (@(posedge CLK) disable iff (!RST_N)
		power_off |=> ANALOG_SEL == 8'h00)
		else $error("channel routed with converter powered off");
	chk_halt_idle: assert property (@(posedge CLK) disable iff (!RST_N)
		halted |=> st_reg == ST_IDLE)
		else $error("sequencer ran while halted");
	chk_irq_set: assert property (@(posedge CLK) disable iff (!RST_N)
		store && ien_reg |=> irq_reg)
		else $error("interrupt not raised after conversion");
	chk_lock_keep: assert property (@(posedge CLK) disable iff (!RST_N)
		locked |=> $stable(res_reg))
		else $error("result changed while interlocked");
	chk_cont_restart: assert property (@(posedge CLK) disable iff (!RST_N)
		conv_end && cont_reg && !wr_sc && !power_off && !halted
		|=> st_reg == ST_SAMPLE)
		else $error("continuous mode did not restart");
	chk_done_noirq: assert property (@(posedge CLK) disable iff (!RST_N)
		ien_reg |=> !done_reg)
		else $error("done flag set in interrupt mode");
	chk_irq_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		wr_sc && !store |=> !irq_reg)
		else $error("interrupt not cleared by control write");
	chk_pin_zero: assert property (@(posedge CLK) disable iff (!RST_N)
		PIN_OE == (PIN_OE & ~ANALOG_SEL))
		else $error("selected pin still driven");
	chk_single_stop: assert property (@(posedge CLK) disable iff (!RST_N)
		conv_end && !cont_reg && !wr_sc |=> st_reg == ST_IDLE)
		else $error("single mode did not stop");
	chk_signed_msb: assert property (@(posedge CLK) disable iff (!RST_N)
		mode == SAC_SIGNED |-> hi_view[7] != res_reg[9])
		else $error("signed mode msb not inverted");
	chk_trunc_high: assert property (@(posedge CLK) disable iff (!RST_N)
		mode == SAC_TRUNC |-> hi_view == 8'h00)
		else $error("truncation high byte not zero");
	cov_single: cover property (@(posedge CLK) conv_end && !cont_reg);
	cov_cont: cover property (@(posedge CLK) conv_end && cont_reg);
	cov_locked: cover property (@(posedge CLK) conv_end && locked);
	cov_irq: cover property (@(posedge CLK) store && ien_reg);
	cov_trunc: cover property (@(posedge CLK) conv_end && mode == SAC_TRUNC);
endmodule
`default_nettype wire

/* sac_control_bench.sv */
// Purpose: register-level bench for the converter control
// Assumes: analog model stands in for the comparator array
// Notes: results checked against the ideal codes of the model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module sac_control_bench
	import sac_pkg::*;
;
	typedef struct packed {
		sac_just_t m;
		logic [2:0] ch;
		logic [9:0] v;
		logic [7:0] hi;
		logic [7:0] lo;
	} sac_case_t;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, idle = 1'h0, halt = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, comp, irq, pwr;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] pin_out, pin_oe, asel;
	logic [9:0] dac;
	logic [9:0] vin [8] = '{default: 10'h000};
	int error_cnt = 0;
	int total_checks = 0;
	sac_case_t tbl [5] = '{'{SAC_LEFT, 3'h0, 10'h3fc, 8'hff, 8'h00},
		'{SAC_RIGHT, 3'h7, 10'h3ff, 8'h03, 8'hff},
		'{SAC_RIGHT, 3'h1, 10'h000, 8'h00, 8'h00},
		'{SAC_SIGNED, 3'h3, 10'h1fc, 8'hff, 8'h00},
		'{SAC_TRUNC, 3'h5, 10'h155, 8'h00, 8'h55}};
	always #2.5 clk = ~clk;
	sac_control dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .PORT_PIN_IN(8'hff), .PORT_DATA(8'hff),
		.PORT_DIR(8'hff), .COMP_OUT(comp), .BUS_CLK_EN(1'h1),
		.IDLE_MODE(idle), .HALT_MODE(halt), .PIN_OUT(pin_out),
		.PIN_OE(pin_oe), .ANALOG_SEL(asel), .DAC_CODE(dac), .SAMPLE(),
		.CONV_POWER(pwr), .CONV_IRQ(irq));
	sac_analog_model core (.CLK(clk), .ANALOG_SEL(asel), .DAC_CODE(dac),
		.CONV_POWER(pwr), .VIN(vin), .COMP_OUT(comp));
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		$display("[ERR] %0t wait ran out", $time);
		wrap_up();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'h0;
		if (n == 50) hang();
	endtask
	task automatic rd(input logic [3:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		d = rdata;
		rready <= 1'h0;
		if (n == 50) hang();
	endtask
	// polls the flag; each poll is a full read cycle
	task automatic wait_done();
		int n;
		for (n = 0; n < 200; n++) begin
			rd(SAC_OFS_STATUS_CONTROL);
			if (d[SAC_BIT_DONE] === 1'h1) break;
		end
		if (n == 200) hang();
	endtask
	task automatic chk_res(input logic [7:0] hi, input logic [7:0] lo);
		rd(SAC_OFS_RESULT_HIGH);
		`CHK(d, {24'h0, hi})
		rd(SAC_OFS_RESULT_LOW);
		`CHK(d, {24'h0, lo})
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		rd(SAC_OFS_STATUS_CONTROL);
		`CHK(d, 32'h0000_001f)
		`CHK(pwr, 1'h0)
		wr(4'h2, 32'h0);
		`CHK(resp, SAC_RESP_SLVERR)
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			vin[tbl[i].ch] <= tbl[i].v;
			// divide by 16 so the synced comparator settles per trial bit
			wr(SAC_OFS_CLOCK, {24'h0, 3'h4, 1'h0, tbl[i].m, 2'h0});
			wr(SAC_OFS_STATUS_CONTROL, {29'h0, tbl[i].ch});
			wait_done();
			`CHK(asel, 8'h01 << tbl[i].ch)
			`CHK(pin_oe[tbl[i].ch], 1'h0)
			chk_res(tbl[i].hi, tbl[i].lo);
			rd(SAC_OFS_STATUS_CONTROL);
			`CHK(d[SAC_BIT_DONE], 1'h0)
		end
		`CHK(pin_oe, 8'hdf)
		$display("format test done");
		vin[0] <= 10'h2a5;
		wr(SAC_OFS_CLOCK, {24'h0, 3'h4, 1'h0, SAC_RIGHT, 2'h0});
		wr(SAC_OFS_STATUS_CONTROL, 32'h0);
		wait_done();
		rd(SAC_OFS_RESULT_HIGH);
		vin[0] <= 10'h155;
		wr(SAC_OFS_STATUS_CONTROL, 32'h0);
		repeat (300) @(posedge clk);
		rd(SAC_OFS_RESULT_LOW);
		`CHK(d, 32'h0000_00a5)
		wr(SAC_OFS_CLOCK, {24'h0, 3'h4, 1'h0, SAC_RIGHT, 2'h0});
		wr(SAC_OFS_STATUS_CONTROL, 32'h0);
		wait_done();
		chk_res(8'h01, 8'h55);
		$display("interlock test done");
		vin[0] <= 10'h100;
		wr(SAC_OFS_STATUS_CONTROL, 32'h0000_0020);
		wait_done();
		chk_res(8'h01, 8'h00);
		// the next conversion is still sampling, so it sees the new level
		vin[0] <= 10'h0c3;
		wait_done();
		chk_res(8'h00, 8'hc3);
		wait_done();
		chk_res(8'h00, 8'hc3);
		wr(SAC_OFS_STATUS_CONTROL, 32'h0);
		wait_done();
		chk_res(8'h00, 8'hc3);
		repeat (60) @(posedge clk);
		rd(SAC_OFS_STATUS_CONTROL);
		`CHK(d[SAC_BIT_DONE], 1'h0)
		$display("continuous test done");
		// converter left powered: its interrupt must wake the processor
		idle <= 1'h1;
		wr(SAC_OFS_STATUS_CONTROL, 32'h0000_0040);
		for (int n = 0; n < 600 && irq !== 1'h1; n++) @(posedge clk);
		`CHK(irq, 1'h1)
		rd(SAC_OFS_STATUS_CONTROL);
		`CHK(d[SAC_BIT_DONE], 1'h0)
		chk_res(8'h00, 8'hc3);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'h0)
		idle <= 1'h0;
		$display("interrupt test done");
		wr(SAC_OFS_STATUS_CONTROL, 32'h0);
		halt <= 1'h1;
		repeat (60) @(posedge clk);
		rd(SAC_OFS_STATUS_CONTROL);
		`CHK(d[SAC_BIT_DONE], 1'h0)
		halt <= 1'h0;
		repeat (300) @(posedge clk);
		wr(SAC_OFS_STATUS_CONTROL, 32'h0);
		wait_done();
		chk_res(8'h00, 8'hc3);
		$display("halt test done");
		wrap_up();
	end
endmodule
`default_nettype wire

/* sac_pkg.sv */
// Purpose: shared constants and types for the converter control block
// Assumes: AXI4-Lite register access, one 200 MHz clock
// Notes: registers sit one per aligned 32-bit word
package sac_pkg;
	localparam logic [3:0] SAC_OFS_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] SAC_OFS_RESULT_HIGH = 4'h4;
	localparam logic [3:0] SAC_OFS_RESULT_LOW = 4'h8;
	localparam logic [3:0] SAC_OFS_CLOCK = 4'hc;
	localparam logic [4:0] SAC_OFS_PORT = 5'h10;
	// status/control fields
	localparam int SAC_BIT_DONE = 7;
	localparam int SAC_BIT_IEN = 6;
	localparam int SAC_BIT_CONT = 5;
	// clock register fields
	localparam int SAC_BIT_DIV_LO = 5;
	localparam int SAC_BIT_ICLK = 4;
	localparam int SAC_BIT_MODE_LO = 2;
	localparam logic [4:0] SAC_CH_OFF = 5'h1f;
	localparam logic [4:0] SAC_CH_RESET = 5'h1f;
	localparam logic [7:0] SAC_CLOCK_RESET = 8'h00;
	localparam logic [4:0] SAC_CONV_CYCLES = 5'h10;
	localparam logic [1:0] SAC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SAC_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SAC_LEFT, SAC_RIGHT, SAC_SIGNED, SAC_TRUNC}
		sac_just_t;
	typedef struct packed {
		logic [9:0] code;
		logic valid;
	} sac_result_t;
endpackage
